//--- logic/cddc_pkg.sv
package cddc_pkg;
	// loading modes
	typedef enum logic [1:0] {
		CDDC_MODE_SLAVE_SERIAL,
		CDDC_MODE_MASTER_SERIAL,
		CDDC_MODE_EXPRESS,
		CDDC_MODE_RESERVED
	} cddc_mode_t;

	// loader phases
	typedef enum logic [1:0] {
		CDDC_ST_LOADING,
		CDDC_ST_USER
	} cddc_state_t;

	localparam int          CDDC_SYNC_STAGES = 3;   // pin synchroniser depth
	localparam int          CDDC_BYTE_W      = 8;   // parallel data width
	localparam logic [7:0]  CDDC_BYTE_RST    = 8'h00; // captured byte at reset
	localparam logic        CDDC_PULL_HIGH   = 1'b1;  // level of a pulled-up pin
	localparam logic        CDDC_FWD_RST     = 1'b1;  // forwarded bit at reset
	localparam logic [15:0] CDDC_DOUT_DELAY  = 16'h0001; // falling edges after capture
endpackage : cddc_pkg

//--- logic/cddc_sync.sv
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser with agreement filter
module cddc_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         reset_n,
	// asynchronous input and filtered level
	input  wire logic [W-1:0] async_in,
	output var  logic [W-1:0] level_q
);
	logic [W-1:0] s1_q; // first stage, read only by s2
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	// shift chain
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// level changes only when stages two and three agree
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			level_q <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					level_q[i] <= s2_q[i];
				end
			end
		end
	end
endmodule : cddc_sync
`default_nettype wire

//--- logic/cddc_port.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - sample serial input on config clock rise
// - forward bit on fall, 1.5 periods later
// - byte mode takes eight parallel inputs
// - chain select enables byte capture in express mode
// - serial output drives next chain select
// - pins become user pins after configuration
// - unconfigured user pins read high
// - init pin low on data error while loading
module cddc_port
	import cddc_pkg::*;
(
	// system clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// mode and completion control
	input  wire logic [1:0]  load_mode,
	input  wire logic        config_done,
	input  wire logic        data_error,
	// link pins from the upstream source
	input  wire logic        config_clock,
	input  wire logic        serial_in,
	input  wire logic        chain_select_in,
	input  wire logic [7:0]  parallel_config_data,
	// serial output pin, three signals
	input  wire logic        serial_out_i,
	output logic             serial_out_o,
	output logic             serial_out_oe,
	// open-drain init pin
	output logic             init_o,
	output logic             init_oe,
	// loader side
	output logic             bit_valid,
	output logic             bit_data,
	output logic             byte_valid,
	output logic [7:0]       byte_data,
	// user side after configuration
	input  wire logic        user_out,
	input  wire logic        user_oe,
	output logic             user_serial_in,
	output logic [7:0]       user_parallel_in,
	output logic             user_serial_out_in,
	output logic             loading
);
	logic [10:0]  sync_q;     // filtered pin levels
	logic         config_clock_s;     // filtered config clock
	logic         din_s;
	logic         cs_s;
	logic [7:0]   dpar_s;
	logic         config_clock_prev_q; // previous clock level for edges
	logic         rise;
	logic         fall;
	logic         fwd_q;       // newest bit captured
	logic         fwd_old_q;   // bit before it, next to leave
	logic         fwd_pend_q;  // at least one capture seen
	logic         fwd_pend2_q; // two captures seen, old slot valid
	// the pipeline holds one whole period of data so that a bit
	// leaves on the fall after the following rise
	cddc_state_t  state_q;
	cddc_mode_t   mode;

	// every link pin crosses through the filter
	cddc_sync #(.W(11)) u_sync (
		.clk      (clk),
		.reset_n  (reset_n),
		.async_in ({config_clock, serial_in, chain_select_in, parallel_config_data}),
		.level_q  (sync_q)
	);

	// split the filtered bus back into its pins; all share one latency,
	// so data and clock keep their relative timing through the filter
	assign config_clock_s = sync_q[10];
	assign din_s  = sync_q[9];
	assign cs_s   = sync_q[8];
	assign dpar_s = sync_q[7:0];
	assign mode   = cddc_mode_t'(load_mode);
	assign rise   = config_clock_s & ~config_clock_prev_q;
	assign fall   = ~config_clock_s & config_clock_prev_q;

	// serial modes share one path
	function automatic logic is_serial(input cddc_mode_t m);
		return (m == CDDC_MODE_SLAVE_SERIAL) || (m == CDDC_MODE_MASTER_SERIAL);
	endfunction : is_serial

	// edge detection on the filtered clock
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			config_clock_prev_q <= 1'b0;
		end else begin
			config_clock_prev_q <= config_clock_s;
		end
	end

	// phase: loading until done, then user pins
	// done is sticky: only reset brings the pins back to loading
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_q <= CDDC_ST_LOADING;
		end else begin
			unique case (state_q)
				CDDC_ST_LOADING: if (config_done) state_q <= CDDC_ST_USER;
				CDDC_ST_USER:    state_q <= CDDC_ST_USER;
				default:         state_q <= CDDC_ST_LOADING;
			endcase
		end
	end

	// serial capture on rising config clock
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			bit_valid <= 1'b0;
			bit_data  <= 1'b0;
		end else begin
			bit_valid <= 1'b0;
			if (state_q == CDDC_ST_LOADING && is_serial(mode) && rise) begin
				bit_valid <= 1'b1;
				bit_data  <= din_s;
			end
		end
	end

	// byte capture; sampled on the rise while selected, trusting the source
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			byte_valid <= 1'b0;
			byte_data  <= CDDC_BYTE_RST;
		end else begin
			byte_valid <= 1'b0;
			if (state_q == CDDC_ST_LOADING && mode == CDDC_MODE_EXPRESS && rise && cs_s) begin
				byte_valid <= 1'b1;
				byte_data  <= dpar_s;
			end
		end
	end

	// two-deep store: a bit waits behind the newest capture, so the
	// fall after the following rise shows it, one and a half periods
	// after it was taken at the input
	// limitation: the last bit of a frame leaves only once the source
	// gives one more rise; a chain source keeps clocking, so this holds
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			fwd_q       <= CDDC_FWD_RST;
			fwd_old_q   <= CDDC_FWD_RST;
			fwd_pend_q  <= 1'b0;
			fwd_pend2_q <= 1'b0;
		end else if (rise && is_serial(mode)) begin
			fwd_q       <= din_s;
			fwd_old_q   <= fwd_q;
			fwd_pend_q  <= 1'b1;
			fwd_pend2_q <= fwd_pend_q;
		end
	end

	// serial output pin: forwarded data, status, or user drive
	// user phase wins over any loading role of the pin
	// status is low while loading so the next device waits its turn
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			serial_out_o  <= CDDC_PULL_HIGH;
			serial_out_oe <= 1'b0;
		end else if (state_q == CDDC_ST_USER) begin
			serial_out_o  <= user_out;
			serial_out_oe <= user_oe;
		end else if (mode == CDDC_MODE_EXPRESS) begin
			serial_out_o  <= cs_s & config_done;
			serial_out_oe <= 1'b1;
		end else if (is_serial(mode) && fall && fwd_pend2_q) begin
			// only a bit one whole period old goes out
			serial_out_o  <= fwd_old_q;
			serial_out_oe <= 1'b1;
		end
	end

	// open-drain init: drive low on error while loading
	// the level stays zero; only the enable moves, as an open drain must
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			init_o  <= 1'b0;
			init_oe <= 1'b0;
		end else begin
			init_o  <= 1'b0;
			init_oe <= (state_q == CDDC_ST_LOADING) && data_error;
		end
	end

	// user view of pins: high until configured, pull-up level
	// user logic never sees loading traffic on these pins
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			user_serial_in     <= CDDC_PULL_HIGH;
			user_parallel_in   <= {CDDC_BYTE_W{CDDC_PULL_HIGH}};
			user_serial_out_in <= CDDC_PULL_HIGH;
			loading            <= 1'b1;
		end else if (state_q == CDDC_ST_USER) begin
			user_serial_in     <= din_s;
			user_parallel_in   <= dpar_s;
			user_serial_out_in <= serial_out_i;
			loading            <= 1'b0;
		end else begin
			user_serial_in     <= CDDC_PULL_HIGH;
			user_parallel_in   <= {CDDC_BYTE_W{CDDC_PULL_HIGH}};
			user_serial_out_in <= CDDC_PULL_HIGH;
			loading            <= 1'b1;
		end
	end
endmodule : cddc_port
`default_nettype wire

//--- bench/cddc_port_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// loading-phase and user-phase checks on the port pins
module cddc_port_monitor (
	// clock and reset
	input wire logic       clk,
	input wire logic       reset_n,
	// watched pins
	input wire logic [1:0] load_mode,
	input wire logic       data_error,
	input wire logic       config_done,
	input wire logic       chain_select_in,
	input wire logic       serial_out_o,
	input wire logic       serial_out_oe,
	input wire logic       init_oe,
	input wire logic       bit_valid,
	input wire logic       bit_data,
	input wire logic       byte_valid,
	input wire logic [7:0] user_parallel_in,
	input wire logic       user_serial_in,
	input wire logic       loading
);
	logic cur_bit_q;  // newest captured bit
	logic prev_bit_q; // bit before it, the one due out next
	// track the last two captures to predict the forwarded bit
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cur_bit_q  <= 1'b1;
			prev_bit_q <= 1'b1;
		end else if (bit_valid) begin
			cur_bit_q  <= bit_data;
			prev_bit_q <= cur_bit_q;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_bit_single: assert property (bit_valid |=> !bit_valid) else $error("bit pulse long");
	a_bit_mode: assert property (bit_valid |-> !load_mode[1]) else $error("bit in byte mode");
	a_byte_gate: assert property (byte_valid |-> load_mode == 2'h2 && $past(chain_select_in, 4))
		else $error("byte not enabled");
	a_fwd_bit: assert property ($past(reset_n) && loading && !load_mode[1] && $changed(serial_out_o)
		|-> serial_out_o == prev_bit_q) else $error("forward bit");
	a_status_low: assert property ($past(reset_n) && $past(loading) && load_mode == 2'h2
		&& !$past(config_done) |-> serial_out_oe && !serial_out_o) else $error("status out");
	a_init_err: assert property (loading && data_error |-> ##[1:6] init_oe) else $error("init");
	a_pins_high: assert property ($past(loading) && loading |-> user_serial_in && &user_parallel_in)
		else $error("pins not high");
	a_user_quiet: assert property (!loading |-> !bit_valid && !byte_valid) else $error("late");
endmodule : cddc_port_monitor
bind cddc_port cddc_port_monitor i_mon (.*);
`default_nettype wire

//--- bench/cddc_src_model.sv
`timescale 1ns/1ps
`default_nettype none
// upstream source; link clock idles low between frames
module cddc_src_model (
	input  wire logic       clk,
	output var  logic       config_clock,
	output var  logic       serial_in,
	output var  logic [7:0] parallel_config_data
);
	initial begin
		config_clock <= 1'b0;
		serial_in <= 1'b1;
		parallel_config_data <= 8'hFF;
	end
	// serial frame msb first, else one byte; 80 ns link period
	task automatic send(input logic [7:0] d, input logic ser);
		for (int i = 7; i >= (ser ? 0 : 7); i--) begin
			serial_in <= d[i];
			parallel_config_data <= d;
			repeat (4) @(posedge clk);
			config_clock <= 1'b1;
			repeat (4) @(posedge clk);
			config_clock <= 1'b0;
		end
		// released lines must not keep their value
		@(posedge clk);
		serial_in <= ~d[ser ? 0 : 7];
		parallel_config_data <= ~d;
	endtask : send
endmodule : cddc_src_model
`default_nettype wire

//--- bench/cddc_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cddc_port_tb;
	logic clk = 0, reset_n = 0, config_done = 0, data_error = 0, chain_select_in = 0;
	logic [1:0] load_mode = 2'h0;
	logic serial_out_o, serial_out_oe, init_o, init_oe, bit_valid, bit_data, byte_valid;
	logic loading, user_serial_in, user_serial_out_in, last_bit, prev_bit;
	logic user_out = 0, user_oe = 0;
	int n_seen = 0;
	logic [7:0] byte_data, user_parallel_in;
	wire logic config_clock, serial_in;
	wire logic [7:0] parallel_config_data;
	logic eb[$];
	logic [7:0] ey[$];
	int n_fail = 0, samples_checked = 0;
	always #5 clk = ~clk;
	cddc_src_model i_src (.*);
	cddc_port i_dut (.*, .serial_out_i(serial_out_o));
	task automatic check(input string nm, input logic [7:0] s, e);
		samples_checked++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask : check
	// score captures against what was sent
	always @(posedge clk) begin
		if (bit_valid) begin
			prev_bit <= last_bit;
			last_bit <= eb[0];
			n_seen <= n_seen + 1;
			check("bit", bit_data, eb.pop_front());
		end
		if (byte_valid) check("byte", byte_data, ey.pop_front());
	end
	// forwarded bit, sampled before the next fall
	always @(posedge config_clock) begin
		#25;
		if (n_seen >= 2 && loading && !load_mode[1]) check("fwd", serial_out_o, prev_bit);
	end
	task automatic rst(input logic [1:0] m);
		reset_n <= 0;
		load_mode <= m;
		config_done <= 0;
		data_error <= 0;
		user_out <= 0;
		user_oe <= 0;
		n_seen <= 0;
		repeat (3) @(posedge clk);
		reset_n <= 1;
		repeat (5) @(posedge clk);
	endtask : rst
	task automatic t_serial(input logic [1:0] m);
		rst(m);
		check("pins", user_parallel_in, 8'hFF);
		for (int k = 0; k < 2; k++) begin
			for (int i = 7; i >= 0; i--) eb.push_back(k ? 1'(8'h3C >> i) : 1'(8'hA5 >> i));
			i_src.send(k ? 8'h3C : 8'hA5, 1'b1);
		end
		repeat (10) @(posedge clk);
		check("left", 8'(eb.size()), 8'h00);
	endtask : t_serial
	task automatic t_byte();
		rst(2'h2);
		chain_select_in <= 1;
		repeat (8) @(posedge clk);
		ey.push_back(8'h5A);
		i_src.send(8'h5A, 1'b0);
		check("status", {serial_out_oe, serial_out_o}, 8'h02);
		chain_select_in <= 0;
		repeat (8) @(posedge clk);
		i_src.send(8'hFF, 1'b0);
		repeat (10) @(posedge clk);
		check("bytes", 8'(ey.size()), 8'h00);
		chain_select_in <= 1;
		config_done <= 1;
		user_out <= 1;
		user_oe <= 1;
		repeat (10) @(posedge clk);
		check("udrive", {serial_out_oe, serial_out_o}, 8'h03);
		check("user", user_parallel_in, 8'h00);
		check("userin", user_serial_in, 8'h00);
		check("uread", user_serial_out_in, 8'h01);
		check("load", loading, 8'h00);
	endtask : t_byte
	task automatic t_err();
		rst(2'h0);
		data_error <= 1;
		repeat (8) @(posedge clk);
		check("init", {init_oe, init_o}, 8'h02);
		config_done <= 1;
		repeat (4) @(posedge clk);
		check("initusr", {init_oe, init_o}, 8'h00);
		data_error <= 0;
	endtask : t_err
	task automatic conclude();
		$display("checked %0d failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : conclude
	initial begin
		#100000;
		n_fail++;
		conclude();
	end
	initial begin
		t_serial(2'h0);
		t_serial(2'h1);
		t_byte();
		t_err();
		conclude();
	end
endmodule : cddc_port_tb
`default_nettype wire
